// ==== rtl/cfc_top.v ====
`timescale 1ns/1ps
`include "cfc_map.vh"
module cfc_top (
    input wire clk_i,
    input wire resetn_i,
    input wire dmap_mode_i,
    input wire tso_mode_i,
    input wire req_valid_i,
    input wire [2:0] req_op_i,
    input wire [`CFC_AW-1:0] req_addr_i,
    input wire [7:0] req_be_i,
    input wire req_cacheable_i,
    input wire req_side_effect_i,
    input wire req_spec_i,
    input wire [`CFC_L2_WAY_BITS-1:0] req_way_i,
    output reg req_ready_o,
    output reg done_o,
    output reg hit_o,
    output reg trap_o,
    output reg mem_rd_o,
    output reg mem_wb_o,
    output reg [`CFC_AW-1:0] mem_addr_o,
    output reg [7:0] mem_be_o,
    output reg mem_nc_o,
    input wire mem_ack_i,
    output reg d1_inv_o,
    output reg [`CFC_D1_SUBS-1:0] d1_inv_sub_o,
    output reg i1_inv_o,
    output reg [`CFC_I1_SUBS-1:0] i1_inv_sub_o,
    output reg [`CFC_AW-1:0] l1_inv_addr_o
);
    localparam S_IDLE = 5'h01;
    localparam S_LOOK = 5'h02;
    localparam S_WB = 5'h04;
    localparam S_FILL = 5'h08;
    localparam S_NC = 5'h10;
    localparam SB = `CFC_L2_OFS_BITS;
    localparam TB = `CFC_L2_OFS_BITS + `CFC_L2_SET_BITS;

    ////////////////////////////////////////////////////////////////
    reg [4:0] state;
    reg [2:0] op;
    reg [`CFC_AW-1:0] addr;
    reg [7:0] be;
    reg [`CFC_L2_WAY_BITS-1:0] way_sel;
    reg [`CFC_L2_WAY_BITS-1:0] rr_way;
    reg after_wb_fill;
    wire [`CFC_L2_SET_BITS-1:0] set_idx = addr[TB-1:SB];
    wire [`CFC_L2_TAG_BITS-1:0] tag_val = addr[`CFC_AW-1:TB];
    wire [`CFC_L2_WAYS-1:0] way_hit;
    wire [`CFC_L2_WAYS-1:0] way_valid;
    wire [`CFC_L2_WAYS-1:0] way_dirty;
    wire [`CFC_L2_TAG_BITS-1:0] way_tag [0:`CFC_L2_WAYS-1];
    reg [`CFC_L2_WAYS-1:0] way_wr;
    reg [`CFC_L2_WAYS-1:0] way_inv;
    reg [`CFC_L2_WAYS-1:0] way_dset;
    reg [`CFC_L2_WAY_BITS-1:0] hit_way;
    reg any_hit;
    reg [`CFC_L2_WAY_BITS-1:0] vict_way;
    integer w;

    genvar g;
    generate
        for (g = 0; g < `CFC_L2_WAYS; g = g + 1) begin : g_way
            cfc_way u_way (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .set_i(set_idx),
                .tag_i(tag_val),
                .wr_i(way_wr[g]),
                .inv_i(way_inv[g]),
                .dirty_set_i(way_dset[g]),
                .wr_tag_i(tag_val),
                .hit_o(way_hit[g]),
                .valid_o(way_valid[g]),
                .dirty_o(way_dirty[g]),
                .tag_o(way_tag[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    always @* begin
        any_hit = 1'b0;
        hit_way = {`CFC_L2_WAY_BITS{1'b0}};
        for (w = 0; w < `CFC_L2_WAYS; w = w + 1) begin
            if (way_hit[w]) begin
                any_hit = 1'b1;
                hit_way = w[`CFC_L2_WAY_BITS-1:0];
            end
        end
        if (dmap_mode_i) begin
            vict_way = addr[TB+`CFC_L2_WAY_BITS-1:TB]; // R17 R04
        end else begin
            vict_way = rr_way;
        end
    end

    wire is_load = (req_op_i == `CFC_OP_LOAD) || (req_op_i == `CFC_OP_IFETCH);
    // Attributes decoded separately; side effect alone keeps the cache path
    wire go_nc = !req_cacheable_i; // R09 R16
    wire bad_atomic = (req_op_i == `CFC_OP_ATOMIC) && !req_cacheable_i; // R08
    wire bad_spec = is_load && req_spec_i && req_side_effect_i; // R15
    wire is_maint = (req_op_i == `CFC_OP_FLUSH) || (req_op_i == `CFC_OP_DIAGINV);

    ////////////////////////////////////////////////////////////////
    // Single outstanding request gives program order across both domains
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= S_IDLE;
            op <= `CFC_OP_LOAD;
            addr <= {`CFC_AW{1'b0}};
            be <= 8'h00;
            way_sel <= {`CFC_L2_WAY_BITS{1'b0}};
            rr_way <= {`CFC_L2_WAY_BITS{1'b0}};
            after_wb_fill <= 1'b0;
            req_ready_o <= 1'b0;
            done_o <= 1'b0;
            hit_o <= 1'b0;
            trap_o <= 1'b0;
            mem_rd_o <= 1'b0;
            mem_wb_o <= 1'b0;
            mem_addr_o <= {`CFC_AW{1'b0}};
            mem_be_o <= 8'h00;
            mem_nc_o <= 1'b0;
            d1_inv_o <= 1'b0;
            d1_inv_sub_o <= {`CFC_D1_SUBS{1'b0}};
            i1_inv_o <= 1'b0;
            i1_inv_sub_o <= {`CFC_I1_SUBS{1'b0}};
            l1_inv_addr_o <= {`CFC_AW{1'b0}};
        end else begin
            done_o <= 1'b0;
            trap_o <= 1'b0;
            d1_inv_o <= 1'b0;
            i1_inv_o <= 1'b0;
            case (state)
                S_IDLE: begin
                    req_ready_o <= 1'b1;
                    if (req_valid_i && req_ready_o) begin
                        req_ready_o <= 1'b0;
                        op <= req_op_i;
                        addr <= req_addr_i;
                        be <= req_be_i;
                        way_sel <= req_way_i;
                        hit_o <= 1'b0;
                        if (bad_atomic || bad_spec) begin
                            trap_o <= 1'b1; // R08 R15
                            done_o <= 1'b1;
                            state <= S_IDLE;
                        end else if (go_nc && !is_maint) begin
                            // Byte-granular, never allocated
                            mem_wb_o <= (req_op_i == `CFC_OP_STORE) ||
                                        (req_op_i == `CFC_OP_BLKCOMMIT);
                            mem_rd_o <= (req_op_i != `CFC_OP_STORE) &&
                                        (req_op_i != `CFC_OP_BLKCOMMIT);
                            mem_nc_o <= 1'b1;
                            mem_addr_o <= req_addr_i;
                            mem_be_o <= req_be_i; // R13
                            state <= S_NC; // R10 R14
                        end else begin
                            state <= S_LOOK;
                        end
                    end
                end
                S_LOOK: begin
                    hit_o <= any_hit;
                    if (op == `CFC_OP_DIAGINV) begin
                        // Dirty data dropped on purpose: diagnostic path only
                        done_o <= 1'b1; // R06
                        state <= S_IDLE;
                    end else if (op == `CFC_OP_FLUSH) begin
                        if (way_valid[way_sel] && way_dirty[way_sel]) begin
                            mem_wb_o <= 1'b1; // R02
                            mem_nc_o <= 1'b0;
                            mem_be_o <= 8'hff;
                            mem_addr_o <= {way_tag[way_sel], set_idx, {SB{1'b0}}};
                            after_wb_fill <= 1'b0;
                            state <= S_WB;
                        end else begin
                            done_o <= 1'b1;
                            state <= S_IDLE;
                        end
                    end else if (any_hit) begin
                        // Hit stays in its way even in direct-map mode
                        done_o <= 1'b1; // R05
                        state <= S_IDLE;
                    end else if (way_valid[vict_way] && way_dirty[vict_way]) begin
                        mem_wb_o <= 1'b1; // R02 R04
                        mem_nc_o <= 1'b0;
                        mem_be_o <= 8'hff;
                        mem_addr_o <= {way_tag[vict_way], set_idx, {SB{1'b0}}};
                        way_sel <= vict_way;
                        after_wb_fill <= 1'b1;
                        state <= S_WB;
                    end else begin
                        // Whole 64-byte line is the system coherence unit
                        mem_rd_o <= 1'b1; // R11
                        mem_nc_o <= 1'b0;
                        mem_be_o <= 8'hff;
                        mem_addr_o <= {tag_val, set_idx, {SB{1'b0}}};
                        way_sel <= vict_way;
                        state <= S_FILL;
                    end
                end
                S_WB: begin
                    if (mem_ack_i) begin
                        mem_wb_o <= 1'b0;
                        if (after_wb_fill) begin
                            mem_rd_o <= 1'b1;
                            mem_addr_o <= {tag_val, set_idx, {SB{1'b0}}};
                            state <= S_FILL;
                        end else begin
                            done_o <= 1'b1;
                            state <= S_IDLE;
                        end
                    end
                end
                S_FILL: begin
                    if (mem_ack_i) begin
                        mem_rd_o <= 1'b0;
                        if (!dmap_mode_i) begin
                            rr_way <= rr_way + 1'b1;
                        end
                        done_o <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                S_NC: begin
                    if (mem_ack_i) begin
                        mem_rd_o <= 1'b0;
                        mem_wb_o <= 1'b0;
                        mem_nc_o <= 1'b0;
                        done_o <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
            // L1 back-invalidate on any L2 line removal; block commit snoop only when the commit does not evict a valid victim
            if (state == S_LOOK) begin
                if (op == `CFC_OP_DIAGINV || op == `CFC_OP_FLUSH ||
                    (!any_hit && way_valid[vict_way])) begin
                    d1_inv_o <= 1'b1; // R03 R01
                    i1_inv_o <= 1'b1; // R03
                    d1_inv_sub_o <= {`CFC_D1_SUBS{1'b1}}; // R12
                    i1_inv_sub_o <= {`CFC_I1_SUBS{1'b1}}; // R12
                    if (op == `CFC_OP_DIAGINV || op == `CFC_OP_FLUSH) begin
                        l1_inv_addr_o <= {way_tag[way_sel], set_idx, {SB{1'b0}}};
                    end else begin
                        l1_inv_addr_o <= {way_tag[vict_way], set_idx, {SB{1'b0}}};
                    end
                end else if (op == `CFC_OP_BLKCOMMIT) begin
                    // Plain stores touch the I-cache only when they evict a valid victim
                    i1_inv_o <= 1'b1; // R07
                    i1_inv_sub_o <= {`CFC_I1_SUBS{1'b0}};
                    i1_inv_sub_o[addr[5]] <= 1'b1; // R12
                    l1_inv_addr_o <= {addr[`CFC_AW-1:SB], {SB{1'b0}}};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    wire is_maint_q = (op == `CFC_OP_FLUSH) || (op == `CFC_OP_DIAGINV);
    always @* begin
        way_wr = {`CFC_L2_WAYS{1'b0}};
        way_inv = {`CFC_L2_WAYS{1'b0}};
        way_dset = {`CFC_L2_WAYS{1'b0}};
        if (state == S_LOOK && (op == `CFC_OP_DIAGINV ||
            (op == `CFC_OP_FLUSH && !(way_valid[way_sel] && way_dirty[way_sel])))) begin
            way_inv[way_sel] = 1'b1; // R06
        end
        if (state == S_WB && mem_ack_i && !after_wb_fill) begin
            way_inv[way_sel] = 1'b1; // R02
        end
        if (state == S_LOOK && any_hit && op != `CFC_OP_LOAD &&
            op != `CFC_OP_IFETCH && !is_maint_q) begin
            way_dset[hit_way] = 1'b1; // R08
        end
        if (state == S_FILL && mem_ack_i) begin
            way_wr[way_sel] = 1'b1;
            way_dset[way_sel] = (op != `CFC_OP_LOAD) && (op != `CFC_OP_IFETCH);
        end
    end
endmodule

// ==== rtl/cfc_map.vh ====
// Contract
// R01 - A first-level flush only invalidates the entry and never writes anything back.
// R02 - A modified second-level line that is flushed or displaced is written back to memory.
// R03 - Removing a second-level line also removes the matching instruction and data cache blocks.
// R04 - In direct-map mode a read that misses displaces the line in its chosen way, pushing out dirty data.
// R05 - In direct-map mode a read that hits leaves the line in the way where it already sits.
// R06 - A diagnostic invalidate of a second-level line discards it with no write-back.
// R07 - The instruction cache snoops only block commit stores; other code changes need an explicit flush.
// R08 - An atomic access is both a load and a store and is allowed only to a cacheable address.
// R09 - Each access is cacheable or noncacheable according to its translation attribute.
// R10 - In total store order mode all accesses, cacheable or not, leave in program order.
// R11 - System coherence works on a 64-byte unit held by the second-level cache.
// R12 - Primary coherence works on 16-byte data and 32-byte instruction lines tracked by directories.
// R13 - Noncacheable transactions carry byte enables down to a single byte, with no allocation.
// R14 - Side-effect noncacheable accesses are strictly ordered among themselves.
// R15 - A speculative load to a side-effect location is not performed and raises an access trap.
// R16 - The side-effect and cacheable attributes are decoded independently.
// R17 - In direct-map mode the fill way comes from the address bits just above the set index.
`ifndef CFC_MAP_VH
`define CFC_MAP_VH
`define CFC_AW 40
`define CFC_L2_LINE_BYTES 64
`define CFC_L2_OFS_BITS 6
`define CFC_L2_SET_BITS 4
`define CFC_L2_SETS 16
`define CFC_L2_WAYS 4
`define CFC_L2_WAY_BITS 2
`define CFC_L2_TAG_BITS 30
`define CFC_D1_LINE_BYTES 16
`define CFC_I1_LINE_BYTES 32
`define CFC_D1_SUBS 4
`define CFC_I1_SUBS 2
`define CFC_OP_LOAD 3'h0
`define CFC_OP_STORE 3'h1
`define CFC_OP_ATOMIC 3'h2
`define CFC_OP_BLKCOMMIT 3'h3
`define CFC_OP_FLUSH 3'h4
`define CFC_OP_DIAGINV 3'h5
`define CFC_OP_IFETCH 3'h6
`endif

// ==== rtl/cfc_way.v ====
`timescale 1ns/1ps
`include "cfc_map.vh"
module cfc_way (
    input wire clk_i,
    input wire resetn_i,
    input wire [`CFC_L2_SET_BITS-1:0] set_i,
    input wire [`CFC_L2_TAG_BITS-1:0] tag_i,
    input wire wr_i,
    input wire inv_i,
    input wire dirty_set_i,
    input wire [`CFC_L2_TAG_BITS-1:0] wr_tag_i,
    output wire hit_o,
    output wire valid_o,
    output wire dirty_o,
    output wire [`CFC_L2_TAG_BITS-1:0] tag_o
);
    reg [`CFC_L2_SETS-1:0] valid;
    reg [`CFC_L2_SETS-1:0] dirty;
    reg [`CFC_L2_TAG_BITS-1:0] tags [0:`CFC_L2_SETS-1];
    integer k;
    assign valid_o = valid[set_i];
    assign dirty_o = dirty[set_i];
    assign tag_o = tags[set_i];
    assign hit_o = valid[set_i] && (tags[set_i] == tag_i);
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            valid <= {`CFC_L2_SETS{1'b0}};
            dirty <= {`CFC_L2_SETS{1'b0}};
            for (k = 0; k < `CFC_L2_SETS; k = k + 1) begin
                tags[k] <= {`CFC_L2_TAG_BITS{1'b0}};
            end
        end else if (inv_i) begin
            valid[set_i] <= 1'b0;
            dirty[set_i] <= 1'b0;
        end else if (wr_i) begin
            valid[set_i] <= 1'b1;
            dirty[set_i] <= dirty_set_i;
            tags[set_i] <= wr_tag_i;
        end else if (dirty_set_i) begin
            dirty[set_i] <= 1'b1;
        end
    end
endmodule

// ==== dv/cfc_checker.sv ====
`timescale 1ns/1ps
`include "cfc_map.vh"
module cfc_checker (
    input wire clk_i,
    input wire resetn_i,
    input wire req_valid_i,
    input wire [2:0] req_op_i,
    input wire [`CFC_AW-1:0] req_addr_i,
    input wire [7:0] req_be_i,
    input wire req_cacheable_i,
    input wire req_side_effect_i,
    input wire req_spec_i,
    input wire req_ready_o,
    input wire done_o,
    input wire trap_o,
    input wire mem_rd_o,
    input wire mem_wb_o,
    input wire [`CFC_AW-1:0] mem_addr_o,
    input wire [7:0] mem_be_o,
    input wire mem_nc_o,
    input wire mem_ack_i,
    input wire d1_inv_o,
    input wire i1_inv_o,
    input wire [`CFC_AW-1:0] l1_inv_addr_o
);
    wire take = req_valid_i && req_ready_o;
    wire bus_any = mem_rd_o || mem_wb_o;
    logic last_c;
    logic [7:0] last_be;
    logic [`CFC_AW-1:0] last_addr;
    // Attributes of the accepted request, held to judge its memory traffic
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            last_c <= 1'b0;
            last_be <= 8'h00;
            last_addr <= {`CFC_AW{1'b0}};
        end else if (take) begin
            last_c <= req_cacheable_i;
            last_be <= req_be_i;
            last_addr <= req_addr_i;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_trap_end;
        done_o && trap_o && !bus_any;
    endsequence
    sequence s_diag_take;
        take && req_op_i == `CFC_OP_DIAGINV;
    endsequence
    a_atomic_trap: assert property (
        (take && req_op_i == `CFC_OP_ATOMIC && !req_cacheable_i) |=> s_trap_end)
        else $error("atomic to noncacheable not trapped");
    a_spec_trap: assert property (
        (take && req_op_i == `CFC_OP_LOAD && req_spec_i && req_side_effect_i) |=> s_trap_end)
        else $error("speculative side-effect load not trapped");
    a_trap_pulse: assert property (trap_o |-> done_o ##1 !trap_o && !done_o)
        else $error("trap not a single pulse with done");
    a_line_unit: assert property (
        bus_any && !mem_nc_o |-> mem_be_o == 8'hff && mem_addr_o[5:0] == 6'h00)
        else $error("cacheable transfer not a whole line");
    a_nc_attr: assert property (bus_any |-> mem_nc_o == !last_c)
        else $error("cacheability of transfer wrong");
    a_nc_byte: assert property (
        bus_any && mem_nc_o |-> mem_be_o == last_be && mem_addr_o[39:3] == last_addr[39:3])
        else $error("noncacheable enables or address wrong");
    a_wb_hold: assert property (mem_wb_o && !mem_ack_i |=> mem_wb_o && $stable(mem_addr_o))
        else $error("write-back dropped before ack");
    a_diag_quiet: assert property (s_diag_take |=> (!bus_any) [*2])
        else $error("diagnostic invalidate touched memory");
    a_diag_done: assert property (s_diag_take |-> ##[1:4] done_o)
        else $error("diagnostic invalidate not completed");
    a_l1_pair: assert property (d1_inv_o |-> i1_inv_o && l1_inv_addr_o[5:0] == 6'h00)
        else $error("first-level invalidates not paired");
    a_busy_refuse: assert property (take |=> !req_ready_o)
        else $error("second request accepted while busy");
endmodule

// ==== dv/cfc_mem_model.sv ====
`timescale 1ns/1ps
`include "cfc_map.vh"
module cfc_mem_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic rd_i,
    input wire logic wb_i,
    input wire logic [`CFC_AW-1:0] addr_i,
    output logic ack_o
);
    int n_rd;
    int n_wb;
    logic [`CFC_AW-1:0] last_rd;
    logic [`CFC_AW-1:0] last_wb;
    logic [1:0] cnt;
    // Latency walks 0..3 with the transfer count: prompt and slow answers
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_o <= 1'b0;
            cnt <= 2'h0;
            n_rd <= 0;
            n_wb <= 0;
            last_rd <= {`CFC_AW{1'b0}};
            last_wb <= {`CFC_AW{1'b0}};
        end else if (ack_o) begin
            ack_o <= 1'b0;
            cnt <= 2'h0;
            n_rd <= n_rd + (rd_i ? 1 : 0);
            n_wb <= n_wb + (wb_i ? 1 : 0);
            last_rd <= rd_i ? addr_i : last_rd;
            last_wb <= wb_i ? addr_i : last_wb;
        end else if ((rd_i || wb_i) && cnt == 2'(n_rd + n_wb)) begin
            ack_o <= 1'b1;
        end else if (rd_i || wb_i) begin
            cnt <= cnt + 2'h1;
        end
    end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`include "cfc_map.vh"
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
    localparam logic [`CFC_AW-1:0] A = 40'h0012345678;
    localparam logic [`CFC_AW-1:0] D = 40'h00000128c0;
    localparam logic [`CFC_AW-1:0] E = 40'h00000348c0;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic dmap_mode_i = 1'b0;
    logic tso_mode_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic [2:0] req_op_i = 3'h0;
    logic [`CFC_AW-1:0] req_addr_i = 40'h0;
    logic [7:0] req_be_i = 8'h00;
    logic req_cacheable_i = 1'b0;
    logic req_side_effect_i = 1'b0;
    logic req_spec_i = 1'b0;
    logic [1:0] req_way_i = 2'h0;
    logic req_ready_o, done_o, hit_o, trap_o, mem_rd_o, mem_wb_o, mem_nc_o, mem_ack_i;
    logic d1_inv_o, i1_inv_o, got_trap, got_hit;
    logic [`CFC_AW-1:0] mem_addr_o, l1_inv_addr_o, last_inv;
    logic [7:0] mem_be_o;
    logic [3:0] d1_inv_sub_o, last_dsub;
    logic [1:0] i1_inv_sub_o, last_isub;
    int n_i1 = 0;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    cfc_top uut (.clk_i, .resetn_i, .dmap_mode_i, .tso_mode_i, .req_valid_i, .req_op_i,
        .req_addr_i, .req_be_i, .req_cacheable_i, .req_side_effect_i, .req_spec_i, .req_way_i,
        .req_ready_o, .done_o, .hit_o, .trap_o, .mem_rd_o, .mem_wb_o, .mem_addr_o, .mem_be_o,
        .mem_nc_o, .mem_ack_i, .d1_inv_o, .d1_inv_sub_o, .i1_inv_o, .i1_inv_sub_o,
        .l1_inv_addr_o);
    cfc_mem_model mem (.clk_i, .resetn_i, .rd_i(mem_rd_o), .wb_i(mem_wb_o),
        .addr_i(mem_addr_o), .ack_o(mem_ack_i));
    always #5 clk_i = ~clk_i;
    // Mid-cycle capture: a pulse launched with done is seen before the task resumes
    always @(negedge clk_i) begin
        if (d1_inv_o === 1'b1) begin
            last_inv <= l1_inv_addr_o;
            last_dsub <= d1_inv_sub_o;
        end
        if (i1_inv_o === 1'b1) begin
            n_i1 <= n_i1 + 1;
            last_isub <= i1_inv_sub_o;
        end
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // One request at a time: wait for ready, drive valid for one cycle, await done
    task automatic rq(input logic [2:0] op, input logic [`CFC_AW-1:0] a, input logic c,
        input logic se, input logic sp);
        @(posedge clk_i);
        while (req_ready_o !== 1'b1) @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_op_i <= op;
        req_addr_i <= a;
        req_cacheable_i <= c;
        req_side_effect_i <= se;
        req_spec_i <= sp;
        req_way_i <= a[11:10];
        req_be_i <= c ? 8'hff : 8'h08;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        @(posedge clk_i);
        while (done_o !== 1'b1) @(posedge clk_i);
        got_trap = trap_o;
        got_hit = hit_o;
    endtask
    task automatic t_miss_hit();
        int r0;
        r0 = mem.n_rd;
        rq(`CFC_OP_LOAD, A, 1'b1, 1'b0, 1'b0);
        `CHK("fill line", 40'h0012345640, mem.last_rd)
        rq(`CFC_OP_IFETCH, A, 1'b1, 1'b0, 1'b0);
        `CHK("hit flag", 1'b1, got_hit)
        `CHK("single fill", r0 + 1, mem.n_rd)
    endtask
    task automatic t_nc();
        int r0;
        r0 = mem.n_rd;
        rq(`CFC_OP_LOAD, 40'h0080000013, 1'b0, 1'b1, 1'b0);
        rq(`CFC_OP_LOAD, 40'h0080000013, 1'b0, 1'b1, 1'b0);
        `CHK("nc reads", r0 + 2, mem.n_rd)
        rq(`CFC_OP_LOAD, 40'h000abc0040, 1'b1, 1'b1, 1'b0);
        rq(`CFC_OP_LOAD, 40'h000abc0040, 1'b1, 1'b1, 1'b0);
        `CHK("side-effect cached", 1'b1, got_hit)
    endtask
    task automatic t_trap();
        int r0;
        int i0;
        r0 = mem.n_rd;
        rq(`CFC_OP_ATOMIC, 40'h0080000020, 1'b0, 1'b0, 1'b0);
        `CHK("atomic nc trap", 1'b1, got_trap)
        rq(`CFC_OP_LOAD, 40'h0080000020, 1'b0, 1'b1, 1'b1);
        `CHK("spec se trap", 1'b1, got_trap)
        `CHK("no access", r0, mem.n_rd)
        rq(`CFC_OP_LOAD, A, 1'b1, 1'b0, 1'b1);
        `CHK("spec plain", 1'b0, got_trap)
        rq(`CFC_OP_ATOMIC, A, 1'b1, 1'b0, 1'b0);
        `CHK("atomic cached", 1'b0, got_trap)
        i0 = n_i1;
        rq(`CFC_OP_STORE, A, 1'b1, 1'b0, 1'b0);
        `CHK("store no snoop", i0, n_i1)
        rq(`CFC_OP_BLKCOMMIT, A, 1'b1, 1'b0, 1'b0);
        `CHK("commit snoop", i0 + 1, n_i1)
        `CHK("commit half", 2'h2, last_isub)
    endtask
    // D and E share a set and a direct-map way, so E must push D out
    task automatic t_dmap();
        int r0;
        int w0;
        dmap_mode_i <= 1'b1;
        rq(`CFC_OP_LOAD, A, 1'b1, 1'b0, 1'b0);
        `CHK("resident hit", 1'b1, got_hit)
        rq(`CFC_OP_LOAD, D, 1'b1, 1'b0, 1'b0);
        rq(`CFC_OP_STORE, D, 1'b1, 1'b0, 1'b0);
        w0 = mem.n_wb;
        r0 = mem.n_rd;
        rq(`CFC_OP_LOAD, E, 1'b1, 1'b0, 1'b0);
        `CHK("victim wb", w0 + 1, mem.n_wb)
        `CHK("victim addr", D, mem.last_wb)
        `CHK("victim l1 inv", D, last_inv)
        rq(`CFC_OP_FLUSH, E, 1'b1, 1'b0, 1'b0);
        `CHK("clean flush", w0 + 1, mem.n_wb)
        `CHK("flush l1 inv", E, last_inv)
        `CHK("flush d1 sub", 4'hf, last_dsub)
        rq(`CFC_OP_LOAD, E, 1'b1, 1'b0, 1'b0);
        rq(`CFC_OP_STORE, E, 1'b1, 1'b0, 1'b0);
        rq(`CFC_OP_FLUSH, E, 1'b1, 1'b0, 1'b0);
        `CHK("dirty flush addr", E, mem.last_wb)
        rq(`CFC_OP_LOAD, D, 1'b1, 1'b0, 1'b0);
        rq(`CFC_OP_STORE, D, 1'b1, 1'b0, 1'b0);
        rq(`CFC_OP_DIAGINV, D, 1'b1, 1'b0, 1'b0);
        rq(`CFC_OP_LOAD, D, 1'b1, 1'b0, 1'b0);
        `CHK("diag no wb", w0 + 2, mem.n_wb)
        `CHK("diag dropped", r0 + 4, mem.n_rd)
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_miss_hit();
        t_nc();
        t_trap();
        t_dmap();
        tally_and_finish();
    end
endmodule
bind cfc_top cfc_checker chk (.clk_i, .resetn_i, .req_valid_i, .req_op_i, .req_addr_i,
    .req_be_i, .req_cacheable_i, .req_side_effect_i, .req_spec_i, .req_ready_o, .done_o,
    .trap_o, .mem_rd_o, .mem_wb_o, .mem_addr_o, .mem_be_o, .mem_nc_o, .mem_ack_i,
    .d1_inv_o, .i1_inv_o, .l1_inv_addr_o);
